// >>> tcc_pkg.sv
// Constants, register map and mode types for the timer capture/compare channels.
package tcc_pkg;
	localparam logic [2:0] ADDR_CTRL0 = 3'h0;
	localparam logic [2:0] ADDR_VAL0_HI = 3'h1;
	localparam logic [2:0] ADDR_VAL0_LO = 3'h2;
	localparam logic [2:0] ADDR_CTRL1 = 3'h3;
	localparam logic [2:0] ADDR_VAL1_HI = 3'h4;
	localparam logic [2:0] ADDR_VAL1_LO = 3'h5;
	localparam int BIT_FLAG = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_BUF_SEL = 5;
	localparam int BIT_UNBUF_SEL = 4;
	localparam int BIT_ELS_HI = 3;
	localparam int BIT_ELS_LO = 2;
	localparam int BIT_TOV = 1;
	localparam int BIT_MAX = 0;
	localparam logic [6:0] CTRL_RESET = 7'h00;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [1:0] ELS_NONE = 2'h0;
	localparam logic [1:0] ELS_RISE = 2'h1;
	localparam logic [1:0] ELS_FALL = 2'h2;
	localparam logic [1:0] ELS_BOTH = 2'h3;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	typedef enum logic [1:0] {
		MODE_PRESET = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_COMPARE = 2'b10,
		MODE_BUFFERED = 2'b11
	} tcc_mode_t;
endpackage : tcc_pkg

// >>> tcc_val_if.sv
// Signals between the channel controller and one channel value register.
`timescale 1ns/1ps
`default_nettype none
interface tcc_val_if;
	logic wr_hi;
	logic wr_lo;
	logic rd_hi;
	logic rd_lo;
	logic [7:0] wdata;
	logic cap_mode;
	logic cmp_mode;
	logic cap_load;
	logic [15:0] cap_value;
	logic [15:0] value;
	logic cap_block;
	logic cmp_block;
	modport ctl (output wr_hi, wr_lo, rd_hi, rd_lo, wdata, cap_mode, cmp_mode, cap_load,
		cap_value, input value, cap_block, cmp_block);
	modport store (input wr_hi, wr_lo, rd_hi, rd_lo, wdata, cap_mode, cmp_mode, cap_load,
		cap_value, output value, cap_block, cmp_block);
endinterface : tcc_val_if
`default_nettype wire

// >>> tcc_value_reg.sv
// Sixteen-bit channel value register with coherent byte access.
`timescale 1ns/1ps
`default_nettype none
module tcc_value_reg (
	input wire logic ref_clk,
	input wire logic rst,
	tcc_val_if.store bus
);
	import tcc_pkg::*;
	logic [15:0] value_q;
	logic [15:0] value_d;
	logic cap_block_q;
	logic cap_block_d;
	logic cmp_block_q;
	logic cmp_block_d;

	always_comb begin
		value_d = value_q;
		cap_block_d = cap_block_q;
		cmp_block_d = cmp_block_q;
		if (bus.wr_hi) begin
			value_d[15:8] = bus.wdata;
		end
		if (bus.wr_lo) begin
			value_d[7:0] = bus.wdata;
		end
		if (bus.cap_load && !cap_block_q) begin
			value_d = bus.cap_value;
		end
		if (bus.rd_hi && bus.cap_mode) begin
			cap_block_d = 1'b1;
		end
		if (bus.rd_lo || !bus.cap_mode) begin
			cap_block_d = 1'b0;
		end
		if (bus.wr_hi && bus.cmp_mode) begin
			cmp_block_d = 1'b1;
		end
		if (bus.wr_lo || !bus.cmp_mode) begin
			cmp_block_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			value_q <= VALUE_RESET;
			cap_block_q <= 1'b0;
			cmp_block_q <= 1'b0;
		end else begin
			value_q <= value_d;
			cap_block_q <= cap_block_d;
			cmp_block_q <= cmp_block_d;
		end
	end

	assign bus.value = value_q;
	assign bus.cap_block = cap_block_q;
	assign bus.cmp_block = cmp_block_q;
endmodule : tcc_value_reg
`default_nettype wire

// >>> tcc_top.sv
// Two timer channels with input capture, output compare and PWM on their pins.
// Operation
// - Capture edge sets the channel flag.
// - Counter equal to value sets flag.
// - Flag clears by read-then-write-zero only.
// - Event during clearing sequence keeps flag.
// - Interrupt enable gates channel requests.
// - Buffered select exists only in channel 0.
// - Buffered mode disables channel 1 except its value register.
// - Unbuffered bit picks compare or capture.
// - With edge field zero, sets initial level.
// - Edge field zero releases pin to port.
// - Capture edge: rising, falling, or both.
// - Compare action: toggle, clear, or set.
// - Buffered mode uses same pin actions.
// - Toggle on overflow in compare mode.
// - Overflow toggle beats simultaneous compare action.
// - Full-duty bit forces constant PWM level.
// - Full-duty change applies next PWM period.
// - Value holds capture or compare value.
// - High byte read blocks captures until low.
// - High byte write blocks compares until low.
// - Overflow input marks counter reaching modulo.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tcc_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [15:0] counter_value,
	input wire logic counter_overflow,
	input wire logic [1:0] channel_pin_in,
	output logic [1:0] channel_pin_out,
	output logic [1:0] channel_pin_oe,
	output logic [1:0] channel_irq
);
	import tcc_pkg::*;

	// Decodes a control word into the operating mode of its channel.
	function automatic tcc_mode_t mode_of(input logic [6:0] ctrl);
		tcc_mode_t m;
		m = MODE_PRESET;
		if (ctrl[BIT_ELS_HI:BIT_ELS_LO] == ELS_NONE) begin
			m = MODE_PRESET;
		end else if (ctrl[BIT_BUF_SEL]) begin
			m = MODE_BUFFERED;
		end else if (ctrl[BIT_UNBUF_SEL]) begin
			m = MODE_COMPARE;
		end else begin
			m = MODE_CAPTURE;
		end
		return m;
	endfunction : mode_of

	// Applies the selected compare action to the present pin level.
	function automatic logic pin_action(input logic [1:0] act, input logic cur);
		logic r;
		r = cur;
		case (act)
			ACT_TOGGLE: begin
				r = ~cur;
			end
			ACT_CLEAR: begin
				r = 1'b0;
			end
			ACT_SET: begin
				r = 1'b1;
			end
			default: begin
				r = cur;
			end
		endcase
		return r;
	endfunction : pin_action

	logic [6:0] ctrl_q [2];
	logic [6:0] ctrl_d [2];
	logic [6:0] ctrl_eff [2];
	logic [1:0] flag_q;
	logic [1:0] flag_d;
	logic [1:0] arm_q;
	logic [1:0] arm_d;
	logic [1:0] pin_prev_q;
	logic [1:0] pin_prev_d;
	logic [1:0] pin_out_q;
	logic [1:0] pin_out_d;
	logic [1:0] max_act_q;
	logic [1:0] max_act_d;
	logic buf_sel_q;
	logic buf_sel_d;
	logic buf_pend_q;
	logic buf_pend_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	tcc_mode_t mode [2];
	logic [1:0] cap_hit;
	logic [1:0] cmp_hit;
	logic [1:0] event_hit;
	logic [1:0] ctrl_wr;
	logic [1:0] ctrl_rd;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [15:0] cmp_value [2];
	logic [1:0] cmp_blocked;

	tcc_val_if vif [2] ();

	for (genvar g = 0; g < 2; g++) begin : g_val
		tcc_value_reg u_value (
			.ref_clk(ref_clk),
			.rst(rst),
			.bus(vif[g])
		);
	end

	assign vif[0].wr_hi = bus_wr && bus_addr == ADDR_VAL0_HI;
	assign vif[0].wr_lo = bus_wr && bus_addr == ADDR_VAL0_LO;
	assign vif[0].rd_hi = bus_rd && bus_addr == ADDR_VAL0_HI;
	assign vif[0].rd_lo = bus_rd && bus_addr == ADDR_VAL0_LO;
	assign vif[1].wr_hi = bus_wr && bus_addr == ADDR_VAL1_HI;
	assign vif[1].wr_lo = bus_wr && bus_addr == ADDR_VAL1_LO;
	assign vif[1].rd_hi = bus_rd && bus_addr == ADDR_VAL1_HI;
	assign vif[1].rd_lo = bus_rd && bus_addr == ADDR_VAL1_LO;
	assign vif[0].wdata = bus_wdata;
	assign vif[1].wdata = bus_wdata;
	assign vif[0].cap_value = counter_value;
	assign vif[1].cap_value = counter_value;
	assign vif[0].cap_mode = mode[0] == MODE_CAPTURE;
	assign vif[1].cap_mode = mode[1] == MODE_CAPTURE;
	assign vif[0].cmp_mode = mode[0] == MODE_COMPARE || mode[0] == MODE_BUFFERED;
	assign vif[1].cmp_mode = mode[1] == MODE_COMPARE || mode[0] == MODE_BUFFERED;
	assign vif[0].cap_load = cap_hit[0];
	assign vif[1].cap_load = cap_hit[1];

	assign ctrl_wr[0] = bus_wr && bus_addr == ADDR_CTRL0;
	assign ctrl_wr[1] = bus_wr && bus_addr == ADDR_CTRL1;
	assign ctrl_rd[0] = bus_rd && bus_addr == ADDR_CTRL0;
	assign ctrl_rd[1] = bus_rd && bus_addr == ADDR_CTRL1;

	// Channel 1 sees an all-zero control word while channel 0 has its buffered select bit set.
	always_comb begin
		ctrl_eff[0] = ctrl_q[0];
		ctrl_eff[1] = ctrl_q[0][BIT_BUF_SEL] ? CTRL_RESET : ctrl_q[1];
		mode[0] = mode_of(ctrl_eff[0]);
		mode[1] = mode_of(ctrl_eff[1]);
	end

	// Buffered compare takes the value from whichever register was loaded last before the latest overflow.
	always_comb begin
		cmp_value[0] = buf_sel_q && mode[0] == MODE_BUFFERED ? vif[1].value : vif[0].value;
		cmp_value[1] = vif[1].value;
		cmp_blocked[0] = vif[0].cmp_block;
		if (mode[0] == MODE_BUFFERED) begin
			cmp_blocked[0] = vif[0].cmp_block || vif[1].cmp_block;
		end
		cmp_blocked[1] = vif[1].cmp_block;
	end

	// Event detection for both channels.
	always_comb begin
		rise = channel_pin_in & ~pin_prev_q;
		fall = ~channel_pin_in & pin_prev_q;
		pin_prev_d = channel_pin_in;
		for (int i = 0; i < 2; i++) begin
			cap_hit[i] = 1'b0;
			cmp_hit[i] = 1'b0;
			if (mode[i] == MODE_CAPTURE && !vif_cap_block(i)) begin
				case (ctrl_eff[i][BIT_ELS_HI:BIT_ELS_LO])
					ELS_RISE: begin
						cap_hit[i] = rise[i];
					end
					ELS_FALL: begin
						cap_hit[i] = fall[i];
					end
					ELS_BOTH: begin
						cap_hit[i] = rise[i] | fall[i];
					end
					default: begin
						cap_hit[i] = 1'b0;
					end
				endcase
			end
			if ((mode[i] == MODE_COMPARE || mode[i] == MODE_BUFFERED) && !cmp_blocked[i]) begin
				cmp_hit[i] = counter_value == cmp_value[i];
			end
		end
		event_hit = cap_hit | cmp_hit;
	end

	// Returns the capture block of the value register of one channel.
	function automatic logic vif_cap_block(input int idx);
		logic r;
		r = vif[1].cap_block;
		if (idx == 0) begin
			r = vif[0].cap_block;
		end
		return r;
	endfunction : vif_cap_block

	// Control bits and the two-step flag clearing sequence.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ctrl_d[i] = ctrl_q[i];
			flag_d[i] = flag_q[i];
			arm_d[i] = arm_q[i];
			if (ctrl_rd[i] && flag_q[i]) begin
				arm_d[i] = 1'b1;
			end
			if (ctrl_wr[i] && !(i == 1 && ctrl_q[0][BIT_BUF_SEL])) begin
				ctrl_d[i] = bus_wdata[6:0];
				if (arm_q[i] && !bus_wdata[BIT_FLAG]) begin
					flag_d[i] = 1'b0;
				end
				arm_d[i] = 1'b0;
			end
			if (event_hit[i]) begin
				flag_d[i] = 1'b1;
				arm_d[i] = 1'b0;
			end
		end
		ctrl_d[1][BIT_BUF_SEL] = 1'b0;
	end

	// Pin level, overflow toggling and full-duty forcing.
	always_comb begin
		buf_sel_d = buf_sel_q;
		buf_pend_d = buf_pend_q;
		if (vif[0].wr_lo) begin
			buf_pend_d = 1'b0;
		end
		if (vif[1].wr_lo) begin
			buf_pend_d = 1'b1;
		end
		if (counter_overflow) begin
			buf_sel_d = buf_pend_d;
		end
		for (int i = 0; i < 2; i++) begin
			pin_out_d[i] = pin_out_q[i];
			max_act_d[i] = max_act_q[i];
			if (counter_overflow) begin
				max_act_d[i] = ctrl_eff[i][BIT_MAX] && ctrl_eff[i][BIT_TOV];
			end
			case (mode[i])
				MODE_PRESET: begin
					pin_out_d[i] = ~ctrl_eff[i][BIT_UNBUF_SEL];
				end
				MODE_COMPARE, MODE_BUFFERED: begin
					if (counter_overflow && ctrl_eff[i][BIT_TOV]) begin
						pin_out_d[i] = ~pin_out_q[i];
					end else if (cmp_hit[i]) begin
						pin_out_d[i] = pin_action(ctrl_eff[i][BIT_ELS_HI:BIT_ELS_LO],
							pin_out_q[i]);
					end
					if (max_act_d[i] && ctrl_eff[i][BIT_TOV]) begin
						pin_out_d[i] = 1'b1;
					end
				end
				default: begin
					pin_out_d[i] = pin_out_q[i];
				end
			endcase
		end
	end

	// Read data for the cycle after the read strobe.
	always_comb begin
		rdata_d = RDATA_RESET;
		if (bus_rd) begin
			case (bus_addr)
				ADDR_CTRL0: begin
					rdata_d = {flag_q[0], ctrl_q[0]};
				end
				ADDR_CTRL1: begin
					rdata_d = {flag_q[1], ctrl_q[1]};
				end
				ADDR_VAL0_HI: begin
					rdata_d = vif[0].value[15:8];
				end
				ADDR_VAL0_LO: begin
					rdata_d = vif[0].value[7:0];
				end
				ADDR_VAL1_HI: begin
					rdata_d = vif[1].value[15:8];
				end
				ADDR_VAL1_LO: begin
					rdata_d = vif[1].value[7:0];
				end
				default: begin
					rdata_d = RDATA_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_q[0] <= CTRL_RESET;
			ctrl_q[1] <= CTRL_RESET;
			flag_q <= 2'h0;
			arm_q <= 2'h0;
			pin_prev_q <= 2'h0;
			pin_out_q <= 2'h3;
			max_act_q <= 2'h0;
			buf_sel_q <= 1'b0;
			buf_pend_q <= 1'b0;
			rdata_q <= RDATA_RESET;
		end else begin
			ctrl_q[0] <= ctrl_d[0];
			ctrl_q[1] <= ctrl_d[1];
			flag_q <= flag_d;
			arm_q <= arm_d;
			pin_prev_q <= pin_prev_d;
			pin_out_q <= pin_out_d;
			max_act_q <= max_act_d;
			buf_sel_q <= buf_sel_d;
			buf_pend_q <= buf_pend_d;
			rdata_q <= rdata_d;
		end
	end

	// Only compare modes drive the pin; otherwise the port owns it.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			channel_pin_oe[i] = mode[i] == MODE_COMPARE || mode[i] == MODE_BUFFERED;
			channel_irq[i] = 1'b0;
			if (flag_q[i] && ctrl_q[i][BIT_IRQ_EN]) begin
				channel_irq[i] = 1'b1;
			end
		end
		if (ctrl_q[0][BIT_BUF_SEL]) begin
			channel_irq[1] = 1'b0;
		end
	end

	assign channel_pin_out = pin_out_q;
	assign bus_rdata = rdata_q;
endmodule : tcc_top
`default_nettype wire

// >>> tcc_monitor.sv
// Port checker for the timer capture/compare channels.
`timescale 1ns/1ps
`default_nettype none
module tcc_monitor (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic [1:0] channel_pin_out,
	input wire logic [1:0] channel_pin_oe,
	input wire logic [1:0] channel_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic w0;
	assign w0 = bus_wr && bus_addr == 3'h0;
	property p_pre;
		w0 && bus_wdata[5:2] == 4'h0 |=> !channel_pin_oe[0];
	endproperty
	a_pre: assert property (p_pre) else $error("pin not released");
	property p_lvl;
		w0 && bus_wdata[5:2] == 4'h0 |=> ##2 channel_pin_out[0] == !$past(bus_wdata[4], 3);
	endproperty
	a_lvl: assert property (p_lvl) else $error("preset level wrong");
	property p_cmp;
		w0 && bus_wdata[5:4] == 2'h1 && bus_wdata[3:2] != 2'h0 |=> channel_pin_oe[0];
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare pin not driven");
	property p_cap;
		w0 && bus_wdata[5:4] == 2'h0 && bus_wdata[3:2] != 2'h0 |=> !channel_pin_oe[0];
	endproperty
	a_cap: assert property (p_cap) else $error("capture pin driven");
	property p_buf;
		w0 && bus_wdata[5] && bus_wdata[3:2] != 2'h0 |=> channel_pin_oe == 2'h1 && !channel_irq[1];
	endproperty
	a_buf: assert property (p_buf) else $error("buffered mode pins wrong");
	property p_ch1;
		bus_rd && bus_addr == 3'h3 |=> !bus_rdata[5];
	endproperty
	a_ch1: assert property (p_ch1) else $error("channel 1 buffered bit set");
	property p_ien;
		w0 && !bus_wdata[6] |=> !channel_irq[0];
	endproperty
	a_ien: assert property (p_ien) else $error("request while disabled");
	property p_irq;
		bus_rd && bus_addr == 3'h0 |=> (bus_rdata[7] && bus_rdata[6]) == $past(channel_irq[0]);
	endproperty
	a_irq: assert property (p_irq) else $error("request differs from flag");
	c_cmp: cover property (w0 && bus_wdata[5:4] == 2'h1);
	c_buf: cover property (channel_pin_oe == 2'h1);
	c_irq: cover property (channel_irq[0]);
endmodule : tcc_monitor
bind tcc_top tcc_monitor i_tcc_monitor (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
	.channel_irq(channel_irq));
`default_nettype wire

// >>> tcc_pin_model.sv
// Pin model: the channel drives when enabled, otherwise the outside level.
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	input wire logic [1:0] ext,
	output logic [1:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : tcc_pin_model
`default_nettype wire

// >>> test_tcc_top.sv
// Self-checking bench for the timer capture/compare channels.
`timescale 1ns/1ps
`default_nettype none
module test_tcc_top;
	import tcc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] bus_addr = 3'h0;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_rdata;
	logic [15:0] counter_value = 16'h0000;
	logic counter_overflow = 1'b0;
	logic [1:0] ext = 2'h0;
	logic [1:0] pin_in;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] irq;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] v;
	logic p;
	tcc_top i_tcc_top (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .counter_value(counter_value),
		.counter_overflow(counter_overflow), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
		.channel_pin_oe(pin_oe), .channel_irq(irq));
	tcc_pin_model i_tcc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic rc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1;
		chk(16'(bus_rdata), 16'(exp));
	endtask : rc
	task automatic pulse(input logic [15:0] x, input logic o);
		@(posedge ref_clk);
		counter_value <= x;
		counter_overflow <= o;
		@(posedge ref_clk);
		counter_value <= x + 16'h0001;
		counter_overflow <= 1'b0;
		tick(2);
	endtask : pulse
	function automatic logic act(input logic [1:0] a, input logic q);
		return (a == ACT_TOGGLE) ? !q : (a == ACT_SET);
	endfunction : act
	function automatic logic hit(input logic [1:0] e, input logic rise);
		return rise ? e[0] : e[1];
	endfunction : hit
	initial begin
		logic [15:0] c;
		logic [1:0] e;
		logic r;
		v = 16'($urandom(48089));
		v = VALUE_RESET;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rc(ADDR_CTRL0, 8'h00);
		rc(ADDR_CTRL1, 8'h00);
		wr(3'h6, 8'hff);
		rc(3'h6, 8'h00);
		for (int i = 1; i < 7; i++) begin
			e = 2'((i - 1) % 3 + 1);
			r = i < 4;
			@(posedge ref_clk);
			ext <= {1'b0, !r};
			wr(ADDR_CTRL0, {4'h4, e, 2'h0});
			tick(2);
			c = 16'($urandom);
			@(posedge ref_clk);
			counter_value <= c;
			ext <= {1'b0, r};
			tick(3);
			if (hit(e, r)) begin
				v = c;
			end
			rc(ADDR_CTRL0, {hit(e, r), 3'h4, e, 2'h0});
			rc(ADDR_VAL0_HI, v[15:8]);
			@(posedge ref_clk);
			counter_value <= 16'($urandom);
			ext <= {1'b0, !r};
			tick(3);
			rc(ADDR_VAL0_LO, v[7:0]);
			rc(ADDR_CTRL0, {hit(e, r), 3'h4, e, 2'h0});
			wr(ADDR_CTRL0, 8'h40);
			rc(ADDR_CTRL0, 8'h40);
		end
		v = 16'($urandom);
		wr(ADDR_CTRL0, 8'h10);
		tick(2);
		chk(16'(pin_out[0]), 16'h0000);
		p = 1'b0;
		wr(ADDR_VAL0_HI, v[15:8]);
		wr(ADDR_VAL0_LO, v[7:0]);
		for (int a = 1; a < 4; a++) begin
			wr(ADDR_CTRL0, {4'hd, a[1:0], 2'h0});
			rc(ADDR_CTRL0, {4'h5, a[1:0], 2'h0});
			pulse(v, 1'b0);
			p = act(a[1:0], p);
			chk(16'(pin_out[0]), 16'(p));
			wr(ADDR_CTRL0, {4'h5, a[1:0], 2'h0});
			rc(ADDR_CTRL0, {4'hd, a[1:0], 2'h0});
			wr(ADDR_CTRL0, {4'h5, a[1:0], 2'h0});
			rc(ADDR_CTRL0, {4'h5, a[1:0], 2'h0});
		end
		v[15:8] = ~v[15:8];
		wr(ADDR_VAL0_HI, v[15:8]);
		pulse(v, 1'b0);
		rc(ADDR_CTRL0, 8'h5c);
		wr(ADDR_VAL0_LO, v[7:0]);
		pulse(v, 1'b0);
		rc(ADDR_CTRL0, 8'hdc);
		chk(16'(irq), 16'h0001);
		pulse(v, 1'b0);
		wr(ADDR_CTRL0, 8'h5e);
		rc(ADDR_CTRL0, 8'hde);
		pulse(v, 1'b1);
		p = !p;
		chk(16'(pin_out[0]), 16'(p));
		pulse(v + 16'h8000, 1'b1);
		p = !p;
		chk(16'(pin_out[0]), 16'(p));
		pulse(v + 16'h8000, 1'b1);
		p = !p;
		chk(16'(pin_out[0]), 16'(p));
		wr(ADDR_CTRL0, 8'h5f);
		tick(2);
		chk(16'(pin_out[0]), 16'(p));
		pulse(v + 16'h8000, 1'b1);
		chk(16'(pin_out[0]), 16'h0001);
		pulse(v + 16'h8000, 1'b1);
		chk(16'(pin_out[0]), 16'h0001);
		wr(ADDR_CTRL0, 8'h5e);
		tick(2);
		chk(16'(pin_out[0]), 16'h0001);
		pulse(v + 16'h8000, 1'b1);
		chk(16'(pin_out[0]), 16'h0000);
		p = 1'b0;
		wr(ADDR_CTRL1, 8'h34);
		rc(ADDR_CTRL1, 8'h14);
		wr(ADDR_CTRL0, 8'h24);
		tick(1);
		chk(16'(pin_oe), 16'h0001);
		pulse(v, 1'b0);
		p = act(ACT_TOGGLE, p);
		chk(16'(pin_out[0]), 16'(p));
		wr(ADDR_VAL1_HI, ~v[15:8]);
		wr(ADDR_VAL1_LO, v[7:0]);
		pulse(v ^ 16'hff00, 1'b1);
		chk(16'(pin_out[0]), 16'(p));
		pulse(v ^ 16'hff00, 1'b0);
		p = act(ACT_TOGGLE, p);
		chk(16'(pin_out[0]), 16'(p));
		wr(ADDR_CTRL1, 8'h00);
		wr(ADDR_CTRL0, 8'h00);
		tick(2);
		chk(16'(pin_oe), 16'h0002);
		chk(16'(pin_out[0]), 16'h0001);
		report_and_stop();
	end
endmodule : test_tcc_top
`default_nettype wire
